// *** logic/sec_regs.svh ***
// Summary of operation
// R1: zero override set uses programmed zero code, else code from line rate.
// R2: zero codes 1F..00 select 365,275,195,140,105,75,55,50 MHz.
// R3: automatic zero code: rate 0/1 gives 1F, rate 2 gives 1B, rate 3 08.
// R4: sixteen lane setting registers from 0x1D0, lane 0 lowest address.
// R5: two-bit boost per lane selects 0, 2, 4 or 6 dB.
// R6: level override makes per-lane level 0..16 set equalizer strength.
// R7: lane status level is the bit count of the lane thermometer level.
// R8: lane status shows read-only over and under analysis flags.
// R9: software configures scan, then writing run bit 1 starts the scan.
// R10: host changes scan control only while run bit is zero.
// R11: scan length 0..3 analyzes 127, 1032, 8191 or 65535 samples.
// R12: scan mode for all lanes; 0 off, 1..3 compare all, zeros, ones.
// R13: mode 4 counts samples where the scan sampler reads one.
// R14: modes 8, 9, 10 move offset to average, lowest, highest zero level.
// R15: modes 12, 13, 14 move offset to average, highest, lowest one level.
// R16: zero-only or one-only modes skip samples and so take longer.
// R17: manual level applies only in equalizer mode 1; else full adaptation.
// R18: reserved bits stored without effect; status always shows live state.
`ifndef SEC_REGS_SVH
`define SEC_REGS_SVH
// register indices; byte address is four times the index
`define SEC_IDX_EQ_CTRL 10'h1c2
`define SEC_IDX_ZERO 10'h1c3
`define SEC_IDX_LANE_SET 10'h1d0
`define SEC_IDX_LANE_STS 10'h1e0
`define SEC_IDX_RUN 10'h1f0
`define SEC_IDX_SCAN_CTRL 10'h1f1
`define SEC_IDX_PHASE 10'h1f2
`define SEC_IDX_CNT_LO 10'h200
`define SEC_IDX_CNT_HI 10'h201
`define SEC_IDX_FOUND 10'h202
`define SEC_IDX_LANE_SEL 10'h203
`define SEC_IDX_IRQ_STS 10'h204
`define SEC_IDX_IRQ_MASK 10'h205
`define SEC_IDX_RATE 10'h206
// reset values
`define SEC_RST_LANE_SET 8'h08
`define SEC_RST_ZERO 8'h00
`define SEC_RST_BYTE 8'h00
// field positions
`define SEC_EQ_MODE_LSB 0
`define SEC_EQ_HOLD_BIT 2
`define SEC_EQ_ZOVR_BIT 3
`define SEC_EQ_LOVR_BIT 4
`define SEC_BOOST_LSB 5
`define SEC_LEN_LSB 4
`define SEC_OVER_BIT 6
`define SEC_UNDER_BIT 5
// zero codes
`define SEC_Z365 5'h1f
`define SEC_Z275 5'h1e
`define SEC_Z195 5'h1d
`define SEC_Z140 5'h1b
`define SEC_Z105 5'h19
`define SEC_Z75 5'h10
`define SEC_Z55 5'h08
`define SEC_Z50 5'h00
// sample counts and maximum strength level
`define SEC_LEN0 16'h007f
`define SEC_LEN1 16'h0408
`define SEC_LEN2 16'h1fff
`define SEC_LEN3 16'hffff
`define SEC_MAX_LEVEL 5'h10
`endif

// *** logic/sec_pkg.sv ***
package sec_pkg;
  typedef enum logic [1:0] {
    SEC_IDLE,
    SEC_RUN,
    SEC_DONE
  } sec_scan_state_t;
  typedef enum logic [3:0] {
    SEC_ES_OFF = 4'h0,
    SEC_ES_CMP = 4'h1,
    SEC_ES_CMP0 = 4'h2,
    SEC_ES_CMP1 = 4'h3,
    SEC_ES_ONES = 4'h4,
    SEC_ES_AVG0 = 4'h8,
    SEC_ES_LOW0 = 4'h9,
    SEC_ES_HIGH0 = 4'ha,
    SEC_ES_AVG1 = 4'hc,
    SEC_ES_HIGH1 = 4'hd,
    SEC_ES_LOW1 = 4'he
  } sec_scan_mode_t;
endpackage : sec_pkg

// *** logic/sec_eyescan_ctrl.sv ***
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "sec_regs.svh"
module sec_eyescan_ctrl #(
  parameter int LANES = 16,
  parameter int TW = 16,
  parameter int VW = 6
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // lane equalizer status inputs
  input wire logic [LANES*TW-1:0] therm_level_i,
  input wire logic [LANES-1:0] analysis_over_flag_i,
  input wire logic [LANES-1:0] analysis_under_flag_i,
  // lane sampler inputs
  input wire logic [LANES-1:0] sample_valid_i,
  input wire logic [LANES-1:0] normal_bit_i,
  input wire logic [LANES-1:0] scan_bit_i,
  input wire logic [LANES*VW-1:0] sample_volt_i,
  // equalizer controls
  output logic [1:0] equalizer_mode_select_o,
  output logic eq_hold_o,
  output logic [4:0] zero_code_o,
  output logic [8:0] zero_mhz_o,
  output logic [LANES*2-1:0] gain_boost_select_o,
  output logic [LANES-1:0] manual_level_o,
  output logic [LANES*5-1:0] manual_strength_level_o,
  // eye-scan controls
  output logic scan_active_o,
  output logic [3:0] scan_mode_select_o,
  output logic [6:0] scan_phase_offset_o,
  // interrupt
  output logic irq_o
);

  function automatic logic [4:0] auto_zero(input logic [1:0] rate);
    case (rate)
      2'd2: auto_zero = `SEC_Z140;
      2'd3: auto_zero = `SEC_Z55;
      default: auto_zero = `SEC_Z365;
    endcase
  endfunction : auto_zero

  function automatic logic [8:0] zero_mhz(input logic [4:0] code);
    case (code)
      `SEC_Z365: zero_mhz = 9'd365;
      `SEC_Z275: zero_mhz = 9'd275;
      `SEC_Z195: zero_mhz = 9'd195;
      `SEC_Z140: zero_mhz = 9'd140;
      `SEC_Z105: zero_mhz = 9'd105;
      `SEC_Z75: zero_mhz = 9'd75;
      `SEC_Z55: zero_mhz = 9'd55;
      `SEC_Z50: zero_mhz = 9'd50;
      default: zero_mhz = 9'd0;
    endcase
  endfunction : zero_mhz

  function automatic logic [15:0] scan_len(input logic [1:0] len);
    case (len)
      2'd0: scan_len = `SEC_LEN0;
      2'd1: scan_len = `SEC_LEN1;
      2'd2: scan_len = `SEC_LEN2;
      default: scan_len = `SEC_LEN3;
    endcase
  endfunction : scan_len

  function automatic logic [4:0] popcount(input logic [TW-1:0] t);
    logic [4:0] c;
    c = 5'd0;
    for (int i = 0; i < TW; i++) begin
      c = c + {4'd0, t[i]};
    end
    popcount = c;
  endfunction : popcount

  // bus decode
  logic ack_q;
  logic [31:0] dat_q;
  logic [9:0] idx;
  logic req;
  logic wr;
  logic [7:0] wbyte;
  assign idx = adr_i[11:2];
  assign req = cyc_i & stb_i & ~ack_q;
  assign wr = req & we_i & sel_i[0];
  assign wbyte = dat_i[7:0];
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  logic wr_eq;
  logic wr_zero;
  logic wr_run;
  logic wr_ctrl;
  logic wr_phase;
  logic wr_sel;
  logic wr_ists;
  logic wr_mask;
  logic wr_rate;
  logic lane_hit;
  logic sts_hit;
  logic [3:0] lane_idx;
  assign wr_eq = wr & (idx == `SEC_IDX_EQ_CTRL);
  assign wr_zero = wr & (idx == `SEC_IDX_ZERO);
  assign wr_run = wr & (idx == `SEC_IDX_RUN);
  assign wr_ctrl = wr & (idx == `SEC_IDX_SCAN_CTRL);
  assign wr_phase = wr & (idx == `SEC_IDX_PHASE);
  assign wr_sel = wr & (idx == `SEC_IDX_LANE_SEL);
  assign wr_ists = wr & (idx == `SEC_IDX_IRQ_STS);
  assign wr_mask = wr & (idx == `SEC_IDX_IRQ_MASK);
  assign wr_rate = wr & (idx == `SEC_IDX_RATE);
  assign lane_hit = (idx[9:4] == `SEC_IDX_LANE_SET >> 4); // R4
  assign sts_hit = (idx[9:4] == `SEC_IDX_LANE_STS >> 4);
  assign lane_idx = idx[3:0];

  // control registers; reserved bits kept but unused
  logic [7:0] eq_ctrl_q;
  logic [7:0] zero_q;
  logic [7:0] run_q;
  logic [7:0] ctrl_q;
  logic [7:0] phase_q;
  logic [7:0] lsel_q;
  logic [7:0] mask_q;
  logic [7:0] rate_q;
  logic [7:0] lane_set_q [LANES];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eq_ctrl_q <= `SEC_RST_BYTE;
      zero_q <= `SEC_RST_ZERO;
      run_q <= `SEC_RST_BYTE;
      ctrl_q <= `SEC_RST_BYTE;
      phase_q <= `SEC_RST_BYTE;
      lsel_q <= `SEC_RST_BYTE;
      mask_q <= `SEC_RST_BYTE;
      rate_q <= `SEC_RST_BYTE;
    end else begin
      if (wr_eq) eq_ctrl_q <= wbyte; // R18
      if (wr_zero) zero_q <= wbyte;
      if (wr_run) run_q <= wbyte;
      if (wr_ctrl) ctrl_q <= wbyte; // R10
      if (wr_phase) phase_q <= wbyte;
      if (wr_sel) lsel_q <= wbyte;
      if (wr_mask) mask_q <= wbyte;
      if (wr_rate) rate_q <= wbyte;
    end
  end

  // equalizer outputs
  logic [1:0] eq_mode;
  logic lvl_ovr;
  assign eq_mode = eq_ctrl_q[`SEC_EQ_MODE_LSB +: 2];
  assign lvl_ovr = eq_ctrl_q[`SEC_EQ_LOVR_BIT] & (eq_mode == 2'd1); // R17
  assign equalizer_mode_select_o = eq_mode;
  // hold only freezes a fully adaptive loop
  assign eq_hold_o = eq_ctrl_q[`SEC_EQ_HOLD_BIT] & (eq_mode == 2'd1)
                     & ~eq_ctrl_q[`SEC_EQ_LOVR_BIT];
  assign zero_code_o = eq_ctrl_q[`SEC_EQ_ZOVR_BIT] ? zero_q[4:0] // R1
                       : auto_zero(rate_q[1:0]); // R3
  assign zero_mhz_o = zero_mhz(zero_code_o); // R2
  assign scan_mode_select_o = ctrl_q[3:0]; // R12
  assign scan_phase_offset_o = phase_q[6:0];

  // eye-scan sequencing
  sec_pkg::sec_scan_state_t st_q;
  sec_pkg::sec_scan_state_t st_d;
  logic start;
  logic all_done;
  logic [LANES-1:0] lane_done;
  logic [15:0] len;
  logic [3:0] mode;
  assign start = wr_run & wbyte[0] & ~run_q[0]; // R9
  assign all_done = &lane_done;
  assign len = scan_len(ctrl_q[`SEC_LEN_LSB +: 2]); // R11
  assign mode = ctrl_q[3:0];
  assign scan_active_o = (st_q == sec_pkg::SEC_RUN);

  always_comb begin
    st_d = st_q;
    case (st_q)
      sec_pkg::SEC_IDLE: begin
        if (start) st_d = sec_pkg::SEC_RUN;
      end
      sec_pkg::SEC_RUN: begin
        if (wr_run & ~wbyte[0]) st_d = sec_pkg::SEC_IDLE;
        else if (all_done) st_d = sec_pkg::SEC_DONE;
      end
      sec_pkg::SEC_DONE: begin
        if (wr_run & ~wbyte[0]) st_d = sec_pkg::SEC_IDLE;
      end
      default: st_d = sec_pkg::SEC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) st_q <= sec_pkg::SEC_IDLE;
    else st_q <= st_d;
  end

  // mode classes
  logic use_all;
  logic use_zero;
  logic use_one;
  logic err_cmp;
  logic err_ones;
  assign use_all = (mode == sec_pkg::SEC_ES_CMP)
                   | (mode == sec_pkg::SEC_ES_ONES);
  assign use_zero = (mode == sec_pkg::SEC_ES_CMP0)
                    | (mode == sec_pkg::SEC_ES_AVG0)
                    | (mode == sec_pkg::SEC_ES_LOW0)
                    | (mode == sec_pkg::SEC_ES_HIGH0);
  assign use_one = (mode == sec_pkg::SEC_ES_CMP1)
                   | (mode == sec_pkg::SEC_ES_AVG1)
                   | (mode == sec_pkg::SEC_ES_HIGH1)
                   | (mode == sec_pkg::SEC_ES_LOW1);
  assign err_cmp = (mode == sec_pkg::SEC_ES_CMP)
                   | (mode == sec_pkg::SEC_ES_CMP0)
                   | (mode == sec_pkg::SEC_ES_CMP1);
  assign err_ones = (mode == sec_pkg::SEC_ES_ONES);

  // per-lane engines
  logic [15:0] ecount [LANES];
  logic [VW-1:0] found [LANES];
  logic [7:0] lane_sts [LANES];
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [15:0] ana_q;
      logic [15:0] err_q;
      logic signed [VW-1:0] off_q;
      logic seen_q;
      logic nb;
      logic qual;
      logic hit;
      logic signed [VW-1:0] v;
      logic signed [VW:0] diff;
      logic signed [VW-1:0] avg;
      logic signed [VW-1:0] nxt;
      assign nb = normal_bit_i[g];
      assign v = sample_volt_i[g*VW +: VW];
      assign lane_done[g] = (ana_q == len);
      // skipped samples make the single-level modes slower
      assign qual = scan_active_o & sample_valid_i[g] & ~lane_done[g]
                    & (use_all | (use_zero & ~nb) | (use_one & nb)); // R16
      assign hit = (err_cmp & (nb != scan_bit_i[g])) // R12
                   | (err_ones & scan_bit_i[g]); // R13
      assign diff = {v[VW-1], v} - {off_q[VW-1], off_q};
      // running average: cheap, no divider, settles over a few samples
      assign avg = off_q + VW'(diff >>> 3);
      always_comb begin
        nxt = off_q;
        case (mode)
          sec_pkg::SEC_ES_AVG0, sec_pkg::SEC_ES_AVG1: nxt = avg; // R14 R15
          sec_pkg::SEC_ES_LOW0, sec_pkg::SEC_ES_LOW1: begin
            if (v < off_q) nxt = v; // R14 R15
          end
          sec_pkg::SEC_ES_HIGH0, sec_pkg::SEC_ES_HIGH1: begin
            if (v > off_q) nxt = v; // R14 R15
          end
          default: nxt = off_q;
        endcase
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ana_q <= 16'h0000;
          err_q <= 16'h0000;
          off_q <= '0;
          seen_q <= 1'b0;
        end else if (start) begin
          ana_q <= 16'h0000;
          err_q <= 16'h0000;
          off_q <= '0;
          seen_q <= 1'b0;
        end else if (qual) begin
          ana_q <= ana_q + 16'h0001; // R11
          if (hit) err_q <= err_q + 16'h0001; // R13
          seen_q <= 1'b1;
          off_q <= seen_q ? nxt : v;
        end
      end
      assign ecount[g] = err_q;
      assign found[g] = off_q;
      // live status, never latched
      assign lane_sts[g] = {1'b0, analysis_over_flag_i[g], // R8
                            analysis_under_flag_i[g], // R8
                            popcount(therm_level_i[g*TW +: TW])}; // R7 R18
      assign gain_boost_select_o[g*2 +: 2] =
        lane_set_q[g][`SEC_BOOST_LSB +: 2]; // R5
      // level codes above 16 are clamped to the strongest setting
      assign manual_strength_level_o[g*5 +: 5] =
        (lane_set_q[g][4:0] > `SEC_MAX_LEVEL) ? `SEC_MAX_LEVEL
        : lane_set_q[g][4:0]; // R6
      assign manual_level_o[g] = lvl_ovr; // R6 R17
      always_ff @(posedge clk_i) begin
        if (rst_i) lane_set_q[g] <= `SEC_RST_LANE_SET;
        else if (wr & lane_hit & (lane_idx == 4'(g)))
          lane_set_q[g] <= wbyte; // R4
      end
    end
  endgenerate

  // interrupt events: done, any over rise, any under rise
  logic [LANES-1:0] over_q;
  logic [LANES-1:0] under_q;
  logic done_q;
  logic [2:0] ev;
  logic [7:0] ists_q;
  logic [7:0] ists_d;
  assign ev = {|(analysis_under_flag_i & ~under_q),
               |(analysis_over_flag_i & ~over_q),
               all_done & scan_active_o & ~done_q};
  // a new event wins over a clear in the same cycle
  assign ists_d = (ists_q & ~(wr_ists ? wbyte : 8'h00)) | {5'd0, ev};
  assign irq_o = |(ists_q & mask_q);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      over_q <= '0;
      under_q <= '0;
      done_q <= 1'b0;
      ists_q <= `SEC_RST_BYTE;
    end else begin
      over_q <= analysis_over_flag_i;
      under_q <= analysis_under_flag_i;
      done_q <= all_done & scan_active_o;
      ists_q <= ists_d;
    end
  end

  // read mux
  logic [3:0] ls;
  logic [7:0] rd;
  assign ls = lsel_q[3:0];
  always_comb begin
    rd = 8'h00;
    if (lane_hit) rd = lane_set_q[lane_idx];
    else if (sts_hit) rd = lane_sts[lane_idx]; // R7 R8
    else begin
      case (idx)
        `SEC_IDX_EQ_CTRL: rd = eq_ctrl_q;
        `SEC_IDX_ZERO: rd = zero_q;
        `SEC_IDX_RUN: rd = run_q;
        `SEC_IDX_SCAN_CTRL: rd = ctrl_q;
        `SEC_IDX_PHASE: rd = phase_q;
        `SEC_IDX_CNT_LO: rd = ecount[ls][7:0];
        `SEC_IDX_CNT_HI: rd = ecount[ls][15:8];
        `SEC_IDX_FOUND: rd = {{(8-VW){1'b0}}, found[ls]};
        `SEC_IDX_LANE_SEL: rd = lsel_q;
        `SEC_IDX_IRQ_STS: rd = ists_q;
        `SEC_IDX_IRQ_MASK: rd = mask_q;
        `SEC_IDX_RATE: rd = rate_q;
        default: rd = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      dat_q <= req ? {24'h00_0000, rd} : 32'h0000_0000;
    end
  end

endmodule : sec_eyescan_ctrl
`default_nettype wire

// *** testbench/sec_eyescan_ctrl_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module sec_eyescan_ctrl_monitor #(
  parameter int LANES = 16
) (
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [1:0] equalizer_mode_select_o,
  input wire logic eq_hold_o,
  input wire logic [LANES-1:0] manual_level_o,
  input wire logic scan_active_o,
  input wire logic [3:0] scan_mode_select_o
);
  wire tk = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
  wire run1 = tk && adr_i[11:2] == 10'h1f0 && dat_i[0];
  wire run0 = tk && adr_i[11:2] == 10'h1f0 && !dat_i[0];
  wire ctl_wr = tk && adr_i[11:2] == 10'h1f1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows_req:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked");
  a_ack_single_pulse:
    assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_dat_quiet_idle:
    assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_level_needs_mode:
    assert property (|manual_level_o |->
      equalizer_mode_select_o == 2'd1 && &manual_level_o)
    else $error("manual level outside mode 1");
  a_hold_gated:
    assert property (eq_hold_o |->
      equalizer_mode_select_o == 2'd1 && !(|manual_level_o))
    else $error("hold outside adaptive mode");
  a_run_has_cause:
    assert property ($rose(scan_active_o) |-> $past(run1) || $past(run1, 2))
    else $error("scan started without run write");
  a_run_stops:
    assert property (run0 |-> ##2 !scan_active_o)
    else $error("scan still active after run clear");
  a_mode_follows_wr:
    assert property (ctl_wr |=> scan_mode_select_o == $past(dat_i[3:0]))
    else $error("scan mode not updated");
endmodule : sec_eyescan_ctrl_monitor
bind sec_eyescan_ctrl sec_eyescan_ctrl_monitor #(.LANES(LANES)) u_mon (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
  .ack_o, .equalizer_mode_select_o, .eq_hold_o, .manual_level_o,
  .scan_active_o, .scan_mode_select_o
);
`default_nettype wire

// *** testbench/sec_eyescan_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sec_regs.svh"
module sec_eyescan_ctrl_tb_top;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc_i = 0;
  logic stb_i = 0;
  logic we_i = 0;
  logic [11:0] adr_i = '0;
  logic [3:0] sel_i = 4'h1;
  logic [31:0] dat_i = '0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [255:0] therm_level_i = '0;
  logic [15:0] analysis_over_flag_i = '0;
  logic [15:0] analysis_under_flag_i = '0;
  logic [15:0] sample_valid_i = '0;
  logic [15:0] normal_bit_i = '0;
  logic [15:0] scan_bit_i = '0;
  logic [95:0] sample_volt_i = '0;
  logic [1:0] equalizer_mode_select_o;
  logic eq_hold_o;
  logic [4:0] zero_code_o;
  logic [8:0] zero_mhz_o;
  logic [31:0] gain_boost_select_o;
  logic [15:0] manual_level_o;
  logic [79:0] manual_strength_level_o;
  logic scan_active_o;
  logic [3:0] scan_mode_select_o;
  logic [6:0] scan_phase_offset_o;
  logic irq_o;
  int miscompares = 0;
  int total_checks = 0;
  int cyc_n = 0;
  logic [31:0] rs = 32'h0000_bf6c;
  logic [7:0] q;
  localparam logic [4:0] AZ [4] = '{5'h1f, 5'h1f, 5'h1b, 5'h08};
  localparam logic [4:0] ZC [8] = '{5'h1f, 5'h1e, 5'h1d, 5'h1b, 5'h19,
    5'h10, 5'h08, 5'h00};
  localparam logic [8:0] ZM [8] = '{365, 275, 195, 140, 105, 75, 55, 50};
  localparam logic [3:0] MD [10] = '{1, 2, 3, 4, 8, 9, 10, 12, 13, 14};
  sec_eyescan_ctrl dut (.*);
  always #2 clk_i = ~clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [4:0] pc(input logic [15:0] x);
    pc = 5'd0;
    for (int i = 0; i < 16; i++) pc += 5'(x[i]);
  endfunction : pc
  // sample count per scan length code
  function automatic int slen(input logic [1:0] l);
    case (l)
      2'd0: return 127;
      2'd1: return 1032;
      2'd2: return 8191;
      default: return 65535;
    endcase
  endfunction : slen
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one classic cycle; the request stands until ack is sampled
  task wb(input logic w, input int i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= {i[9:0], 2'b00};
    dat_i <= 32'(d);
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o[7:0];
    cyc_i <= 0;
    stb_i <= 0;
    if (n >= 20) begin
      miscompares++;
      report_and_stop();
    end
  endtask : wb
  task wr(input int i, input logic [7:0] d);
    wb(1, i, d);
  endtask : wr
  task rd(input int i, input logic [7:0] e);
    wb(0, i, 8'h00);
    chk(q, e);
  endtask : rd
  task scan(input logic [3:0] m, input logic [1:0] l);
    int k, c, e, lim;
    logic signed [5:0] f, v;
    logic nb, sb, ok;
    k = 0;
    c = 0;
    e = 0;
    f = '0;
    lim = slen(l);
    wr(`SEC_IDX_SCAN_CTRL, {2'b00, l, m});
    chk(scan_mode_select_o, m);
    wr(`SEC_IDX_IRQ_STS, 8'h01);
    wr(`SEC_IDX_RUN, 8'h01);
    @(posedge clk_i);
    chk(scan_active_o, 1);
    while (k < lim) begin
      rs = lfsr(rs);
      {v, sb, nb} = rs[7:0];
      sample_valid_i <= '1;
      normal_bit_i <= {16{nb}};
      scan_bit_i <= {16{sb}};
      sample_volt_i <= {16{v}};
      @(posedge clk_i);
      c++;
      ok = m == 1 || m == 4 || (m == 2 || m[3:2] == 2'b10) && !nb
        || (m == 3 || m[3:2] == 2'b11) && nb;
      if (ok) begin
        f = (k == 0) ? v : (m == 8 || m == 12)
          ? f + 6'((7'(v) - 7'(f)) >>> 3)
          : (m == 9 || m == 14) ? (v < f ? v : f) : (v > f ? v : f);
        k++;
        e += (m == 4) ? int'(sb) : int'(nb != sb);
      end
    end
    sample_valid_i <= '0;
    chk(c == lim, m == 1 || m == 4);
    k = 0;
    while (scan_active_o !== 1'b0 && k < 20) begin
      @(posedge clk_i);
      k++;
    end
    chk(scan_active_o, 0);
    rd(`SEC_IDX_IRQ_STS, 8'h01);
    chk(irq_o, 1);
    wr(`SEC_IDX_LANE_SEL, 8'(rs[3:0]));
    if (m <= 4) begin
      rd(`SEC_IDX_CNT_LO, e[7:0]);
      rd(`SEC_IDX_CNT_HI, e[15:8]);
    end else begin
      wb(0, `SEC_IDX_FOUND, 8'h00);
      chk(q, {2'b00, f});
    end
    wr(`SEC_IDX_RUN, 8'h00);
  endtask : scan
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    rd(`SEC_IDX_RUN, 8'h00);
    rd(`SEC_IDX_SCAN_CTRL, 8'h00);
    for (int n = 0; n < 16; n++) begin
      rs = lfsr(rs);
      rd(`SEC_IDX_LANE_SET + n, 8'h08);
      wr(`SEC_IDX_LANE_SET + n, rs[7:0]);
      rd(`SEC_IDX_LANE_SET + n, rs[7:0]);
      chk(gain_boost_select_o[n*2+:2], rs[6:5]);
      chk(manual_strength_level_o[n*5+:5], rs[4:0] > 16 ? 16 : rs[4:0]);
    end
    wr(`SEC_IDX_EQ_CTRL, 8'h11);
    chk(equalizer_mode_select_o, 2'd1);
    chk(manual_level_o, 16'hffff);
    wr(`SEC_IDX_EQ_CTRL, 8'h05);
    chk(eq_hold_o, 1);
    wr(`SEC_IDX_EQ_CTRL, 8'h16);
    chk(equalizer_mode_select_o, 2'd2);
    chk({manual_level_o, eq_hold_o}, 0);
    wr(`SEC_IDX_EQ_CTRL, 8'h00);
    for (int n = 0; n < 4; n++) begin
      wr(`SEC_IDX_RATE, 8'(n));
      chk(zero_code_o, AZ[n]);
    end
    wr(`SEC_IDX_EQ_CTRL, 8'h08);
    for (int n = 0; n < 8; n++) begin
      wr(`SEC_IDX_ZERO, {3'b101, ZC[n]});
      chk(zero_code_o, ZC[n]);
      chk(zero_mhz_o, ZM[n]);
    end
    rd(`SEC_IDX_ZERO, {3'b101, ZC[7]});
    wr(`SEC_IDX_PHASE, rs[15:8]);
    chk(scan_phase_offset_o, rs[14:8]);
    for (int n = 0; n < 8; n++) begin
      rs = lfsr(rs);
      therm_level_i[n*32+:32] <= rs;
    end
    analysis_over_flag_i <= rs[15:0] | 16'h0001;
    analysis_under_flag_i <= rs[31:16] | 16'h0001;
    repeat (3) @(posedge clk_i);
    for (int n = 0; n < 16; n++) begin
      rd(`SEC_IDX_LANE_STS + n, {1'b0, analysis_over_flag_i[n],
        analysis_under_flag_i[n], pc(therm_level_i[n*16+:16])});
    end
    wr(`SEC_IDX_LANE_STS, 8'h80);
    rd(`SEC_IDX_LANE_STS, {1'b0, analysis_over_flag_i[0],
      analysis_under_flag_i[0], pc(therm_level_i[15:0])});
    rd(10'h3ff, 8'h00);
    rd(`SEC_IDX_IRQ_STS, 8'h06);
    chk(irq_o, 0);
    wr(`SEC_IDX_IRQ_MASK, 8'h02);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1);
    wr(`SEC_IDX_IRQ_STS, 8'h02);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 0);
    rd(`SEC_IDX_IRQ_STS, 8'h04);
    wr(`SEC_IDX_IRQ_STS, 8'h04);
    wr(`SEC_IDX_IRQ_MASK, 8'h01);
    // mode 0 must never qualify a sample, so the run never ends
    wr(`SEC_IDX_SCAN_CTRL, 8'h00);
    wr(`SEC_IDX_RUN, 8'h01);
    sample_valid_i <= '1;
    repeat (130) @(posedge clk_i);
    sample_valid_i <= '0;
    chk(scan_active_o, 1);
    rd(`SEC_IDX_IRQ_STS, 8'h00);
    rd(`SEC_IDX_CNT_LO, 8'h00);
    wr(`SEC_IDX_RUN, 8'h00);
    for (int n = 0; n < 10; n++) scan(MD[n], 2'd0);
    scan(4'h4, 2'd1);
    report_and_stop();
  end
endmodule : sec_eyescan_ctrl_tb_top
`default_nettype wire
